// file: sysint_pkg.sv
// Purpose: shared constants and types of the system integration control
// Assumes: 16-bit register port, one clock, async active-low reset
// Notes:   field layouts are packed structs, lsb declared last
package sysint_pkg;

    localparam int AW = 4;
    localparam int DW = 16;

    // register offsets
    localparam logic [3:0] OFS_CAUSE    = 4'h0;
    localparam logic [3:0] OFS_PMODE    = 4'h1;
    localparam logic [3:0] OFS_REGUL    = 4'h2;
    localparam logic [3:0] OFS_PROT     = 4'h3;
    localparam logic [3:0] OFS_MISC     = 4'h4;
    localparam logic [3:0] OFS_IRQ_ST   = 4'h5;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h6;

    // edges after release before the synced cause is taken
    localparam logic [1:0] CAP_SETTLE = 2'h2;

    // interrupt bits
    localparam int IRQ_W       = 2;
    localparam int IRQ_CAUSE   = 0;
    localparam int IRQ_REFUSED = 1;

    // protection groups
    localparam int PG_N     = 4;
    localparam int PG_PINS  = 0;
    localparam int PG_CLKS  = 1;
    localparam int PG_PORTD = 2;
    localparam int PG_PMODE = 3;

    // bit of the misc register holding the boot source
    localparam int MISC_BOOT_BIT = 8;

    typedef enum logic [1:0] {
        DMA_OFF      = 2'h0,
        DMA_RUN      = 2'h1,
        DMA_RUN_WAIT = 2'h2,
        DMA_ALL      = 2'h3
    } dma_mode_e;

    typedef enum logic [1:0] {
        HIGH_RAIL_NORMAL    = 2'h0,
        HIGH_RAIL_STANDBY   = 2'h1,
        HIGH_RAIL_POWERDOWN = 2'h2,
        HIGH_RAIL_ILLEGAL   = 2'h3
    } high_rail_mode_e;

    typedef enum logic [1:0] {
        PWR_RUN  = 2'h0,
        PWR_WAIT = 2'h1,
        PWR_STOP = 2'h2
    } pwr_state_e;

    typedef struct packed {
        logic wdog_window;
        logic software;
        logic wdog_cpu;
        logic wdog_refloss;
        logic external;
        logic power_on;
    } cause_s;

    typedef struct packed {
        logic      dma_lock;
        dma_mode_e dma_mode;
        logic      dbg_always;
        logic      wait_lock;
        logic      wait_block;
        logic      stop_lock;
        logic      stop_block;
    } pmode_s;

    typedef struct packed {
        logic            lr_lock;
        logic            lr_stby;
        logic            high_rail_lock;
        high_rail_mode_e high_rail_mode;
        logic            sr12_lock;
        logic            sr12_stby;
    } regul_s;

    typedef struct packed {
        logic lock;
        logic on;
    } prot_s;

    typedef struct packed {
        logic timer_one_master;
        logic i2c_ctrl_trig;
    } misc_s;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic          wr;
        logic          rd;
    } bus_req_s;

    localparam pmode_s PMODE_RST = 8'h00;
    localparam regul_s REGUL_RST = 7'h00;
    localparam misc_s  MISC_RST  = 2'h0;

endpackage

// file: sysint_ctrl.sv
// Purpose: reset cause, low-power gating, regulator modes, write locks
// Assumes: reset_src levels are held stable a few cycles after release
// Notes:   all state is one struct; outputs come from it or gate it
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

// Behaviour
// - six reset cause flags, latest reset
// - external flag set when pin held
// - clock-loss and timeout watchdog flags separate
// - stop entry allowed or blocked, lockable
// - wait entry allowed or blocked, lockable
// - debug clock: tap-gated or always on
// - dma runs per selected power option
// - dma setting lockable until reset
// - boot source rom or flash readable
// - 1.2V regulator normal or standby, lockable
// - 2.7V regulator normal, standby, powerdown, lockable
// - large regulator normal or standby, lockable
// - protection off, on, and locked forms
// - four separate protection groups
// - i2c trigger route selectable
// - interval timer master selectable
module sysint_ctrl (
    input  wire logic                     clock,
    input  wire logic                     rst_b,
    input  wire sysint_pkg::bus_req_s     req,
    output logic [sysint_pkg::DW-1:0]     rdata,
    input  wire logic [5:0]               reset_src,
    input  wire logic                     boot_rom_pin,
    input  wire logic                     tap_enabled,
    input  wire logic                     stop_req,
    input  wire logic                     wait_req,
    input  wire sysint_pkg::pwr_state_e   pwr_state,
    output logic                          stop_enter,
    output logic                          wait_enter,
    output logic                          onchip_debug_clock_en,
    output logic                          dma_en,
    output logic                          sr12_standby,
    output logic [1:0]                    small_reg_high_rail_mode,
    output logic                          lr_standby,
    output logic [sysint_pkg::PG_N-1:0]   group_protect,
    output logic                          i2c_ctrl_trig_sel,
    output logic                          timer_one_master,
    output logic                          irq
);

    typedef struct packed {
        logic [7:0]                      sync1;
        logic [7:0]                      sync2;
        logic [1:0]                      cap_cnt;
        logic                            cap_done;
        sysint_pkg::cause_s              cause;
        logic                            boot_rom;
        sysint_pkg::pmode_s              pm;
        sysint_pkg::regul_s              rg;
        sysint_pkg::prot_s [3:0]         prot;
        sysint_pkg::misc_s               misc;
        logic [sysint_pkg::IRQ_W-1:0]    irq_st;
        logic [sysint_pkg::IRQ_W-1:0]    irq_mask;
        logic [sysint_pkg::DW-1:0]       rdata;
    } state_s;

    state_s                        s_ff;
    state_s                        nxt_s;
    sysint_pkg::pmode_s            wpm;
    sysint_pkg::regul_s            wrg;
    sysint_pkg::prot_s [3:0]       wpr;
    logic [sysint_pkg::IRQ_W-1:0]  ev_set;
    logic [sysint_pkg::IRQ_W-1:0]  ev_clr;
    logic                          refused;
    logic                          wr_pm;
    logic                          wr_rg;
    logic                          wr_pr;

    always_comb begin
        nxt_s   = s_ff;
        ev_set  = '0;
        ev_clr  = '0;
        refused = 1'b0;
        wpm     = sysint_pkg::pmode_s'(req.wdata[7:0]);
        wrg     = sysint_pkg::regul_s'(req.wdata[6:0]);
        wpr     = req.wdata[7:0];
        wr_pm   = req.wr && (req.addr == sysint_pkg::OFS_PMODE);
        wr_rg   = req.wr && (req.addr == sysint_pkg::OFS_REGUL);
        wr_pr   = req.wr && (req.addr == sysint_pkg::OFS_PROT);

        // two-stage synchroniser for pins
        nxt_s.sync1 = {tap_enabled, boot_rom_pin, reset_src};
        nxt_s.sync2 = s_ff.sync1;

        // cause and boot capture once after release
        if (!s_ff.cap_done) begin
            if (s_ff.cap_cnt == sysint_pkg::CAP_SETTLE) begin
                nxt_s.cause    = s_ff.sync2[5:0];
                nxt_s.boot_rom = s_ff.sync2[6];
                nxt_s.cap_done = 1'b1;
                ev_set[sysint_pkg::IRQ_CAUSE] = 1'b1;
            end else begin
                nxt_s.cap_cnt = s_ff.cap_cnt + 2'h1;
            end
        end

        // power mode control register
        if (wr_pm) begin
            if (s_ff.prot[sysint_pkg::PG_PMODE].on) begin
                refused = 1'b1;
            end else begin
                nxt_s.pm.dbg_always = wpm.dbg_always;
                if (!s_ff.pm.stop_lock) begin
                    nxt_s.pm.stop_block = wpm.stop_block;
                    nxt_s.pm.stop_lock  = wpm.stop_lock;
                end else begin
                    refused = 1'b1;
                end
                if (!s_ff.pm.wait_lock) begin
                    nxt_s.pm.wait_block = wpm.wait_block;
                    nxt_s.pm.wait_lock  = wpm.wait_lock;
                end else begin
                    refused = 1'b1;
                end
                if (!s_ff.pm.dma_lock) begin
                    nxt_s.pm.dma_mode = wpm.dma_mode;
                    nxt_s.pm.dma_lock = wpm.dma_lock;
                end else begin
                    refused = 1'b1;
                end
            end
        end

        // regulator modes
        if (wr_rg) begin
            if (!s_ff.rg.sr12_lock) begin
                nxt_s.rg.sr12_stby = wrg.sr12_stby;
                nxt_s.rg.sr12_lock = wrg.sr12_lock;
            end else begin
                refused = 1'b1;
            end
            if (!s_ff.rg.high_rail_lock &&
                wrg.high_rail_mode != sysint_pkg::HIGH_RAIL_ILLEGAL) begin
                nxt_s.rg.high_rail_mode = wrg.high_rail_mode;
                nxt_s.rg.high_rail_lock = wrg.high_rail_lock;
            end else begin
                refused = 1'b1;
            end
            if (!s_ff.rg.lr_lock) begin
                nxt_s.rg.lr_stby = wrg.lr_stby;
                nxt_s.rg.lr_lock = wrg.lr_lock;
            end else begin
                refused = 1'b1;
            end
        end

        // protection groups, each with its own lock
        if (wr_pr) begin
            for (int g = 0; g < sysint_pkg::PG_N; g++) begin
                if (!s_ff.prot[g].lock) begin
                    nxt_s.prot[g] = wpr[g];
                end else begin
                    refused = 1'b1;
                end
            end
        end

        if (req.wr && req.addr == sysint_pkg::OFS_MISC) begin
            nxt_s.misc = req.wdata[1:0];
        end
        if (req.wr && req.addr == sysint_pkg::OFS_IRQ_MASK) begin
            nxt_s.irq_mask = req.wdata[sysint_pkg::IRQ_W-1:0];
        end
        if (req.wr && req.addr == sysint_pkg::OFS_IRQ_ST) begin
            ev_clr = req.wdata[sysint_pkg::IRQ_W-1:0];
        end
        ev_set[sysint_pkg::IRQ_REFUSED] = refused;
        // a new event beats a clear in the same cycle
        nxt_s.irq_st = (s_ff.irq_st & ~ev_clr) | ev_set;

        // read data stands in the cycle after the strobe only
        nxt_s.rdata = '0;
        if (req.rd) begin
            unique case (req.addr)
                sysint_pkg::OFS_CAUSE:
                    nxt_s.rdata = 16'(s_ff.cause);
                sysint_pkg::OFS_PMODE:
                    nxt_s.rdata = 16'(s_ff.pm);
                sysint_pkg::OFS_REGUL:
                    nxt_s.rdata = 16'(s_ff.rg);
                sysint_pkg::OFS_PROT:
                    nxt_s.rdata = 16'(s_ff.prot);
                sysint_pkg::OFS_MISC: begin
                    nxt_s.rdata = 16'(s_ff.misc);
                    nxt_s.rdata[sysint_pkg::MISC_BOOT_BIT] = s_ff.boot_rom;
                end
                sysint_pkg::OFS_IRQ_ST:
                    nxt_s.rdata = 16'(s_ff.irq_st);
                sysint_pkg::OFS_IRQ_MASK:
                    nxt_s.rdata = 16'(s_ff.irq_mask);
                default:
                    nxt_s.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_ff          <= '0;
            s_ff.pm       <= sysint_pkg::PMODE_RST;
            s_ff.rg       <= sysint_pkg::REGUL_RST;
            s_ff.misc     <= sysint_pkg::MISC_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // outputs
    assign rdata                    = s_ff.rdata;
    assign stop_enter               = stop_req & ~s_ff.pm.stop_block;
    assign wait_enter               = wait_req & ~s_ff.pm.wait_block;
    assign onchip_debug_clock_en    = s_ff.pm.dbg_always |
                                      s_ff.sync2[7];
    assign sr12_standby             = s_ff.rg.sr12_stby;
    assign small_reg_high_rail_mode = s_ff.rg.high_rail_mode;
    assign lr_standby               = s_ff.rg.lr_stby;
    assign i2c_ctrl_trig_sel        = s_ff.misc.i2c_ctrl_trig;
    assign timer_one_master         = s_ff.misc.timer_one_master;
    assign irq                      = |(s_ff.irq_st & s_ff.irq_mask);

    always_comb begin
        for (int g = 0; g < sysint_pkg::PG_N; g++) begin
            group_protect[g] = s_ff.prot[g].on;
        end
    end

    always_comb begin
        unique case (s_ff.pm.dma_mode)
            sysint_pkg::DMA_OFF:
                dma_en = 1'b0;
            sysint_pkg::DMA_RUN:
                dma_en = (pwr_state == sysint_pkg::PWR_RUN);
            sysint_pkg::DMA_RUN_WAIT:
                dma_en = (pwr_state == sysint_pkg::PWR_RUN) ||
                         (pwr_state == sysint_pkg::PWR_WAIT);
            sysint_pkg::DMA_ALL:
                dma_en = 1'b1;
        endcase
    end

    // checks
    a_stop_gate: assert property (
        @(posedge clock) disable iff (!rst_b)
        s_ff.pm.stop_block |-> !stop_enter)
        else $error("stop entered while blocked");

    a_wait_gate: assert property (
        @(posedge clock) disable iff (!rst_b)
        s_ff.pm.wait_block |-> !wait_enter)
        else $error("wait entered while blocked");

    a_stop_lock: assert property (
        @(posedge clock) disable iff (!rst_b)
        (wr_pm && s_ff.pm.stop_lock) |=> $stable(s_ff.pm.stop_block))
        else $error("locked stop field changed");

    a_wait_lock: assert property (
        @(posedge clock) disable iff (!rst_b)
        (wr_pm && s_ff.pm.wait_lock) |=> $stable(s_ff.pm.wait_block))
        else $error("locked wait field changed");

    a_cause_take: assert property (
        @(posedge clock) disable iff (!rst_b)
        $rose(s_ff.cap_done) |-> s_ff.cause == $past(s_ff.sync2[5:0], 1))
        else $error("cause not taken from synced sources");

    a_cause_hold: assert property (
        @(posedge clock) disable iff (!rst_b)
        s_ff.cap_done |=> $stable(s_ff.cause))
        else $error("cause changed without reset");

    a_boot_hold: assert property (
        @(posedge clock) disable iff (!rst_b)
        s_ff.cap_done |=> $stable(s_ff.boot_rom))
        else $error("boot source changed without reset");

    a_pm_locked: assert property (
        @(posedge clock) disable iff (!rst_b)
        (wr_pm && s_ff.pm.dma_lock) |=> $stable(s_ff.pm.dma_mode))
        else $error("locked dma field changed");

    a_lock_sticky: assert property (
        @(posedge clock) disable iff (!rst_b)
        s_ff.pm.dma_lock |=> s_ff.pm.dma_lock [*3])
        else $error("dma lock released before reset");

    a_prot_lock: assert property (
        @(posedge clock) disable iff (!rst_b)
        (wr_pr && s_ff.prot[0].lock) |=> $stable(s_ff.prot[0]))
        else $error("locked protection group changed");

    a_pm_protect: assert property (
        @(posedge clock) disable iff (!rst_b)
        (wr_pm && s_ff.prot[sysint_pkg::PG_PMODE].on) |=>
            ($stable(s_ff.pm) && s_ff.irq_st[sysint_pkg::IRQ_REFUSED]))
        else $error("protected power mode register written");

    a_high_rail_lock: assert property (
        @(posedge clock) disable iff (!rst_b)
        (wr_rg && s_ff.rg.high_rail_lock) |=>
            $stable(small_reg_high_rail_mode))
        else $error("locked 2.7V mode changed");

    a_sr12_lock: assert property (
        @(posedge clock) disable iff (!rst_b)
        (wr_rg && s_ff.rg.sr12_lock) |=> $stable(sr12_standby))
        else $error("locked 1.2V mode changed");

    a_lr_lock: assert property (
        @(posedge clock) disable iff (!rst_b)
        (wr_rg && s_ff.rg.lr_lock) |=>
            ($stable(lr_standby) && s_ff.irq_st[sysint_pkg::IRQ_REFUSED]))
        else $error("locked large regulator mode changed");

    a_dma_gate: assert property (
        @(posedge clock) disable iff (!rst_b)
        (s_ff.pm.dma_mode == sysint_pkg::DMA_RUN &&
         pwr_state != sysint_pkg::PWR_RUN) |-> !dma_en)
        else $error("dma enabled outside run mode");

    a_dma_off: assert property (
        @(posedge clock) disable iff (!rst_b)
        (s_ff.pm.dma_mode == sysint_pkg::DMA_OFF) |-> !dma_en)
        else $error("dma enabled while off");

    a_dma_all: assert property (
        @(posedge clock) disable iff (!rst_b)
        (s_ff.pm.dma_mode == sysint_pkg::DMA_ALL) |-> dma_en)
        else $error("dma not enabled in all modes");

    a_dma_stop: assert property (
        @(posedge clock) disable iff (!rst_b)
        (s_ff.pm.dma_mode == sysint_pkg::DMA_RUN_WAIT &&
         pwr_state == sysint_pkg::PWR_STOP) |-> !dma_en)
        else $error("dma enabled in stop mode");

    a_dbg_clock: assert property (
        @(posedge clock) disable iff (!rst_b)
        (!s_ff.pm.dbg_always && !s_ff.sync2[7]) |-> !onchip_debug_clock_en)
        else $error("debug clock on without tap");

    a_read_pulse: assert property (
        @(posedge clock) disable iff (!rst_b)
        !req.rd |=> rdata == '0)
        else $error("read data outside its cycle");

endmodule

// file: test_system_integration_power_control.sv
// Purpose: self-checking bench of the system integration control block
// Assumes: offsets and field layouts of sysint_pkg
// Notes:   register port tasks, table loops for modes
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
    err_total++; $display("FAIL %0t: got %h exp %h", $time, (g), (e)); \
    end end

module test_system_integration_power_control;
    logic                       clock;
    logic                       rst_b;
    sysint_pkg::bus_req_s       req;
    logic [sysint_pkg::DW-1:0]  rdata;
    logic [5:0]                 reset_src;
    logic                       boot_rom_pin;
    logic                       tap_enabled;
    logic                       stop_req;
    logic                       wait_req;
    sysint_pkg::pwr_state_e     pwr_state;
    logic                       stop_enter;
    logic                       wait_enter;
    logic                       onchip_debug_clock_en;
    logic                       dma_en;
    logic                       sr12_standby;
    logic [1:0]                 small_reg_high_rail_mode;
    logic                       lr_standby;
    logic [sysint_pkg::PG_N-1:0] group_protect;
    logic                       i2c_ctrl_trig_sel;
    logic                       timer_one_master;
    logic                       irq;
    logic [3:0]                 rg_out;
    logic                       exp_dma;
    int                         err_total;
    int                         n_compared;
    int                         cycles = 0;

    sysint_ctrl u_sysint_ctrl (
        .clock                    (clock),
        .rst_b                    (rst_b),
        .req                      (req),
        .rdata                    (rdata),
        .reset_src                (reset_src),
        .boot_rom_pin             (boot_rom_pin),
        .tap_enabled              (tap_enabled),
        .stop_req                 (stop_req),
        .wait_req                 (wait_req),
        .pwr_state                (pwr_state),
        .stop_enter               (stop_enter),
        .wait_enter               (wait_enter),
        .onchip_debug_clock_en    (onchip_debug_clock_en),
        .dma_en                   (dma_en),
        .sr12_standby             (sr12_standby),
        .small_reg_high_rail_mode (small_reg_high_rail_mode),
        .lr_standby               (lr_standby),
        .group_protect            (group_protect),
        .i2c_ctrl_trig_sel        (i2c_ctrl_trig_sel),
        .timer_one_master         (timer_one_master),
        .irq                      (irq)
    );

    assign rg_out = {lr_standby, small_reg_high_rail_mode, sr12_standby};

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic end_of_test;
        if (err_total == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clock);
        req.wr <= 1'b0;
        #1;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [15:0] e);
        @(posedge clock);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clock);
        req.rd <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask

    task automatic do_reset(input logic [5:0] src, input logic boot);
        @(posedge clock);
        rst_b <= 1'b0;
        reset_src <= src;
        boot_rom_pin <= boot;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        repeat (6) @(posedge clock);
        #1;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            end_of_test;
        end
    end

    initial begin
        err_total = 0;
        n_compared = 0;
        rst_b = 1'b0;
        req = '0;
        reset_src = 6'h02;
        boot_rom_pin = 1'b1;
        tap_enabled = 1'b0;
        stop_req = 1'b1;
        wait_req = 1'b1;
        pwr_state = sysint_pkg::PWR_RUN;
        do_reset(6'h02, 1'b1);
        rchk(sysint_pkg::OFS_CAUSE, 16'h0002);
        @(posedge clock);
        reset_src <= 6'h3c;
        rchk(sysint_pkg::OFS_CAUSE, 16'h0002);
        rchk(sysint_pkg::OFS_IRQ_ST, 16'h0001);
        `CHK(irq, 1'b0)
        wr(sysint_pkg::OFS_IRQ_MASK, 16'h0003);
        `CHK(irq, 1'b1)
        wr(sysint_pkg::OFS_IRQ_ST, 16'h0001);
        `CHK(irq, 1'b0)
        for (int i = 0; i < 6; i++) begin
            do_reset(6'h01 << i, i[0]);
            rchk(sysint_pkg::OFS_CAUSE, 16'h0001 << i);
            rchk(sysint_pkg::OFS_MISC, {7'h00, i[0], 8'h00});
        end
        // stop, wait and debug clock gating
        wr(sysint_pkg::OFS_PMODE, 16'h0000);
        `CHK({stop_enter, wait_enter}, 2'b11)
        @(posedge clock);
        {stop_req, wait_req} <= 2'b01;
        #1;
        `CHK({stop_enter, wait_enter}, 2'b01)
        @(posedge clock);
        {stop_req, wait_req} <= 2'b11;
        wr(sysint_pkg::OFS_PMODE, 16'h0005);
        `CHK({stop_enter, wait_enter}, 2'b00)
        `CHK(onchip_debug_clock_en, 1'b0)
        @(posedge clock);
        tap_enabled <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
        `CHK(onchip_debug_clock_en, 1'b1)
        @(posedge clock);
        tap_enabled <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
        `CHK(onchip_debug_clock_en, 1'b0)
        wr(sysint_pkg::OFS_PMODE, 16'h0010);
        `CHK(onchip_debug_clock_en, 1'b1)
        // dma option against every power state
        for (int m = 0; m < 4; m++) begin
            wr(sysint_pkg::OFS_PMODE, 16'(m << 5));
            for (int p = 0; p < 3; p++) begin
                @(posedge clock);
                pwr_state <= sysint_pkg::pwr_state_e'(p);
                #1;
                exp_dma = (m == 3) || (m == 2 && p < 2) || (m == 1 && p == 0);
                `CHK(dma_en, exp_dma)
            end
        end
        // write protection groups
        wr(sysint_pkg::OFS_PROT, 16'h0040);
        `CHK(group_protect, 4'b1000)
        wr(sysint_pkg::OFS_PMODE, 16'h0001);
        rchk(sysint_pkg::OFS_PMODE, 16'h0060);
        wr(sysint_pkg::OFS_PROT, 16'h0000);
        wr(sysint_pkg::OFS_PMODE, 16'h0001);
        rchk(sysint_pkg::OFS_PMODE, 16'h0001);
        for (int g = 0; g < 4; g++) begin
            wr(sysint_pkg::OFS_PROT, 16'h0001 << (2 * g));
            `CHK(group_protect, 4'h1 << g)
        end
        wr(sysint_pkg::OFS_PROT, 16'h001b);
        `CHK(group_protect, 4'b0101)
        wr(sysint_pkg::OFS_PROT, 16'h0004);
        rchk(sysint_pkg::OFS_PROT, 16'h000b);
        `CHK(group_protect, 4'b0001)
        // regulator modes, illegal code, locks
        for (int k = 0; k < 3; k++) begin
            wr(sysint_pkg::OFS_REGUL,
               16'((k << 2) | (k & 1) | ((k >> 1) << 5)));
            `CHK(rg_out, {k[1], k[1:0], k[0]})
        end
        wr(sysint_pkg::OFS_REGUL, 16'h000c);
        `CHK(small_reg_high_rail_mode, 2'h2)
        rchk(sysint_pkg::OFS_IRQ_ST, 16'h0003);
        wr(sysint_pkg::OFS_IRQ_MASK, 16'h0003);
        `CHK(irq, 1'b1)
        wr(sysint_pkg::OFS_IRQ_ST, 16'h0003);
        `CHK(irq, 1'b0)
        wr(sysint_pkg::OFS_REGUL, 16'h0077);
        wr(sysint_pkg::OFS_REGUL, 16'h0000);
        rchk(sysint_pkg::OFS_REGUL, 16'h0077);
        `CHK(rg_out, 4'b1011)
        wr(sysint_pkg::OFS_PMODE, 16'h00ff);
        wr(sysint_pkg::OFS_PMODE, 16'h0010);
        rchk(sysint_pkg::OFS_PMODE, 16'h00ff);
        `CHK({stop_enter, wait_enter, dma_en}, 3'b001)
        rchk(sysint_pkg::OFS_IRQ_ST, 16'h0002);
        // trigger route and timer master
        for (int k = 0; k < 4; k++) begin
            wr(sysint_pkg::OFS_MISC, 16'(k));
            `CHK({timer_one_master, i2c_ctrl_trig_sel}, k[1:0])
        end
        rchk(sysint_pkg::OFS_MISC, 16'h0103);
        wr(4'hf, 16'hffff);
        rchk(4'hf, 16'h0000);
        // locks fall only at reset
        do_reset(6'h10, 1'b0);
        rchk(sysint_pkg::OFS_PROT, 16'h0000);
        rchk(sysint_pkg::OFS_REGUL, 16'h0000);
        rchk(sysint_pkg::OFS_PMODE, 16'h0000);
        wr(sysint_pkg::OFS_PMODE, 16'h0005);
        rchk(sysint_pkg::OFS_PMODE, 16'h0005);
        rchk(sysint_pkg::OFS_CAUSE, 16'h0010);
        end_of_test;
    end
endmodule
